// ===== hdl/sph_pkg.sv
// package of constants for the serial process-image handshake
package sph_pkg;
  localparam int          DATA_BYTES     = 64;           // process-image data array size
  localparam int          LEN_W          = 8;            // length field width
  localparam int          ADDR_W         = 8;
  // register offsets (word index on the plain port)
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_STAT       = 8'h01;
  localparam logic [7:0]  OFF_IRQ_STAT   = 8'h02;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h03;
  localparam logic [7:0]  OFF_TX_BASE    = 8'h40;
  localparam logic [7:0]  OFF_RX_BASE    = 8'h80;
  // control word fields
  localparam int          CT_SEND_BIT    = 0;
  localparam int          CT_RXACK_BIT   = 1;
  localparam int          CT_INIT_BIT    = 2;
  localparam int          CT_LEN_LSB     = 8;
  // status word fields
  localparam int          SR_SACK_BIT    = 0;
  localparam int          SR_RXN_BIT     = 1;
  localparam int          SR_IDONE_BIT   = 2;
  localparam int          SR_FULL_BIT    = 3;
  localparam int          SR_LEN_LSB     = 8;
  // interrupt bit positions
  localparam int          IRQ_SENT_BIT   = 0;
  localparam int          IRQ_RX_BIT     = 1;
  localparam int          IRQ_INIT_BIT   = 2;
  localparam int          IRQ_FULL_BIT   = 3;
  localparam int          IRQ_W          = 4;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [3:0]  MASK_RESET     = 4'h0;
  // timing: reinitialization time and serial bit time
  localparam int          CLK_MHZ        = 200;
  localparam int          INIT_TIME_NS   = 100;
  localparam int          INIT_CYCLES    = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int          BAUD           = 115200;
  localparam int          BIT_CYCLES     = (CLK_MHZ * 1000000) / BAUD;
  localparam int          RX_FIFO_DEPTH  = 16;
endpackage

// ===== hdl/sph_uart_phy.sv
// serial line transmitter and receiver, 8N1
`timescale 1ns/1ps
module sph_uart_phy
  import sph_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       txStart,
  input  wire logic [7:0] txData,
  output logic            txBusy,
  output logic            txLine,
  input  wire logic       rxLine,
  output logic            rxValid,
  output logic [7:0]      rxData
);
  localparam int TW = 16;
  localparam logic [TW-1:0] BIT_N  = TW'(BIT_CYCLES - 1);
  localparam logic [TW-1:0] HALF_N = TW'(BIT_CYCLES / 2);

  logic [TW-1:0] txCnt_ff;
  logic [3:0]    txBit_ff;
  logic [9:0]    txShift_ff;
  logic [TW-1:0] rxCnt_ff;
  logic [3:0]    rxBit_ff;
  logic [7:0]    rxShift_ff;
  logic          rxBusy_ff;
  logic          rxSync1_ff;
  logic          rxSync2_ff;

  ////////////////////////////////////////////////////////////
  // transmitter: start, 8 data lsb first, stop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txBusy     <= 1'b0;
      txLine     <= 1'b1;
      txCnt_ff   <= '0;
      txBit_ff   <= '0;
      txShift_ff <= '1;
    end else if (!txBusy) begin
      if (txStart) begin
        txBusy     <= 1'b1;
        txShift_ff <= {1'b1, txData, 1'b0};
        txLine     <= 1'b0;
        txCnt_ff   <= BIT_N;
        txBit_ff   <= 4'h0;
      end
    end else if (txCnt_ff != '0) begin
      txCnt_ff <= txCnt_ff - 1'b1;
    end else if (txBit_ff == 4'h9) begin
      txBusy <= 1'b0;
      txLine <= 1'b1;
    end else begin
      txBit_ff <= txBit_ff + 1'b1;
      txLine   <= txShift_ff[txBit_ff + 1'b1];
      txCnt_ff <= BIT_N;
    end
  end

  ////////////////////////////////////////////////////////////
  // receiver: two-stage sync, mid-bit sampling
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxSync1_ff <= 1'b1;
      rxSync2_ff <= 1'b1;
      rxBusy_ff  <= 1'b0;
      rxCnt_ff   <= '0;
      rxBit_ff   <= '0;
      rxShift_ff <= '0;
      rxValid    <= 1'b0;
      rxData     <= '0;
    end else begin
      rxSync1_ff <= rxLine;
      rxSync2_ff <= rxSync1_ff;
      rxValid    <= 1'b0;
      if (!rxBusy_ff) begin
        if (!rxSync2_ff) begin
          rxBusy_ff <= 1'b1;
          rxCnt_ff  <= HALF_N;
          rxBit_ff  <= 4'h0;
        end
      end else if (rxCnt_ff != '0) begin
        rxCnt_ff <= rxCnt_ff - 1'b1;
      end else begin
        rxCnt_ff <= BIT_N;
        rxBit_ff <= rxBit_ff + 1'b1;
        if (rxBit_ff == 4'h0 && rxSync2_ff) begin
          rxBusy_ff <= 1'b0; // false start
        end else if (rxBit_ff == 4'h9) begin
          rxBusy_ff <= 1'b0;
          if (rxSync2_ff) begin
            rxValid <= 1'b1;
            rxData  <= rxShift_ff;
          end
        end else if (rxBit_ff != 4'h0) begin
          rxShift_ff <= {rxSync2_ff, rxShift_ff[7:1]};
        end
      end
    end
  end
endmodule // sph_uart_phy

// ===== hdl/sph_serial_port.sv
// process-image handshake between controller and serial interface
// Operation
// - control word, status word and data arrays; handshake low, length high
// - any send_toggle change sends exactly out_length bytes on the line
// - after taking the transmit bytes, invert send_ack_toggle
// - on receive, load rx_bytes, set in_length, then invert rx_notify_toggle
// - no new rx_bytes copy until rx_ack_toggle follows rx_notify_toggle
// - in_length always reports valid byte count of rx_bytes
// - init_request rising edge blocks traffic, clears buffers, reinitializes
// - init_done set to 1 when reinitialization has finished
// - init_done cleared once init_request has returned to 0
// - rx_fifo_full_flag high while receive FIFO full; arrivals dropped
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module sph_serial_port
  import sph_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [15:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [15:0]       regRdata,
  output logic                   irq,
  output logic                   serialTx,
  input  wire logic              serialRx
);
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT, ST_INIT} sph_tx_state_t;

  logic [15:0]          ctrlWord_ff;
  logic [7:0]           txBytes_ff [DATA_BYTES];
  logic [7:0]           rxBytes_ff [DATA_BYTES];
  logic [7:0]           fifo_ff    [RX_FIFO_DEPTH];
  logic [3:0]           fifoWr_ff;
  logic [3:0]           fifoRd_ff;
  logic [4:0]           fifoCnt_ff;
  logic                 sendSeen_ff;
  logic                 sendAck_ff;
  logic                 rxNotify_ff;
  logic                 rxAckSeen_ff;
  logic                 rxOwned_ff;
  logic [LEN_W-1:0]     inLength_ff;
  logic                 initDone_ff;
  logic                 initPrev_ff;
  logic [15:0]          initCnt_ff;
  logic [LEN_W-1:0]     sendLen_ff;
  logic [LEN_W-1:0]     sendIdx_ff;
  logic [IRQ_W-1:0]     irqStat_ff;
  logic [IRQ_W-1:0]     irqMask_ff;
  sph_tx_state_t        state_ff;
  logic                 phyStart;
  logic                 phyBusy;
  logic                 phyValid;
  logic [7:0]           phyData;
  logic                 fifoFull;
  logic                 fifoEmpty;
  logic                 initReq;
  logic                 initRise;
  logic                 sendReq;
  logic                 rxAckNew;
  logic                 sentEvt;
  logic                 rxEvt;
  logic                 initEvt;
  logic                 fullEvt;
  logic                 fifoPop;
  logic                 statRd;
  logic [15:0]          statWord;

  // register offset decode helper
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  // byte-array window decode: in range of base..base+DATA_BYTES-1
  function automatic logic inArr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    return (a >= base) && (a < base + ADDR_W'(DATA_BYTES));
  endfunction

  ////////////////////////////////////////////////////////////
  // serial phy
  sph_uart_phy uPhy (
    .clk     (clk),
    .nrst    (nrst),
    .txStart (phyStart),
    .txData  (txBytes_ff[sendIdx_ff[5:0]]),
    .txBusy  (phyBusy),
    .txLine  (serialTx),
    .rxLine  (serialRx),
    .rxValid (phyValid),
    .rxData  (phyData)
  );

  ////////////////////////////////////////////////////////////
  // decoded control bits and toggle detection
  assign initReq   = ctrlWord_ff[CT_INIT_BIT];
  assign initRise  = initReq && !initPrev_ff;
  assign sendReq   = ctrlWord_ff[CT_SEND_BIT] != sendSeen_ff;
  assign rxAckNew  = ctrlWord_ff[CT_RXACK_BIT] != rxAckSeen_ff;
  assign fifoFull  = fifoCnt_ff == 5'(RX_FIFO_DEPTH);
  assign fifoEmpty = fifoCnt_ff == 5'h00;
  assign phyStart  = (state_ff == ST_SEND) && !phyBusy && (sendIdx_ff < sendLen_ff);
  assign statRd    = regRd && hit(regAddr, OFF_IRQ_STAT);

  // status word assembly
  always_comb begin
    statWord               = '0;
    statWord[SR_SACK_BIT]  = sendAck_ff;
    statWord[SR_RXN_BIT]   = rxNotify_ff;
    statWord[SR_IDONE_BIT] = initDone_ff;
    statWord[SR_FULL_BIT]  = fifoFull;
    statWord[15:SR_LEN_LSB] = inLength_ff;
  end

  ////////////////////////////////////////////////////////////
  // control word and transmit byte array writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrlWord_ff <= CTRL_RESET;
    end else if (regWr && hit(regAddr, OFF_CTRL)) begin
      ctrlWord_ff <= regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (regWr && inArr(regAddr, OFF_TX_BASE)) begin
      txBytes_ff[6'(regAddr - OFF_TX_BASE)] <= regWdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////
  // transmit and init sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff    <= ST_IDLE;
      sendSeen_ff <= 1'b0;
      sendAck_ff  <= 1'b0;
      sendLen_ff  <= '0;
      sendIdx_ff  <= '0;
      initPrev_ff <= 1'b0;
      initDone_ff <= 1'b0;
      initCnt_ff  <= '0;
    end else begin
      initPrev_ff <= initReq;
      if (initRise) begin
        state_ff    <= ST_INIT;
        initCnt_ff  <= 16'(INIT_CYCLES);
        sendSeen_ff <= ctrlWord_ff[CT_SEND_BIT];
        sendIdx_ff  <= '0;
        sendLen_ff  <= '0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            if (!initReq) begin
              initDone_ff <= 1'b0;
            end
            if (sendReq && !initReq) begin
              sendSeen_ff <= ctrlWord_ff[CT_SEND_BIT];
              sendLen_ff  <= ctrlWord_ff[15:CT_LEN_LSB];
              sendIdx_ff  <= '0;
              state_ff    <= ST_SEND;
            end
          end
          ST_SEND: begin
            if (phyStart) begin
              sendIdx_ff <= sendIdx_ff + 1'b1;
            end else if (sendIdx_ff >= sendLen_ff) begin
              state_ff <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (!phyBusy) begin
              sendAck_ff <= sendSeen_ff;
              state_ff   <= ST_IDLE;
            end
          end
          ST_INIT: begin
            sendSeen_ff <= ctrlWord_ff[CT_SEND_BIT];
            if (initCnt_ff != '0) begin
              initCnt_ff <= initCnt_ff - 1'b1;
            end else if (!phyBusy && !initDone_ff) begin
              initDone_ff <= 1'b1;
            end else if (initDone_ff && !initReq) begin
              initDone_ff <= 1'b0;
              state_ff    <= ST_IDLE;
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // receive FIFO, dropped when full
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fifoWr_ff  <= '0;
      fifoRd_ff  <= '0;
      fifoCnt_ff <= '0;
    end else if (initRise || state_ff == ST_INIT) begin
      fifoWr_ff  <= '0;
      fifoRd_ff  <= '0;
      fifoCnt_ff <= '0;
    end else begin
      if (phyValid && !fifoFull) begin
        fifoWr_ff <= fifoWr_ff + 1'b1;
      end
      if (fifoPop) begin
        fifoRd_ff <= fifoRd_ff + 1'b1;
      end
      fifoCnt_ff <= fifoCnt_ff + 5'(phyValid && !fifoFull) - 5'(fifoPop);
    end
  end

  always_ff @(posedge clk) begin
    if (phyValid && !fifoFull) begin
      fifo_ff[fifoWr_ff] <= phyData;
    end
  end

  ////////////////////////////////////////////////////////////
  // receive block handover to the controller
  assign fifoPop = !rxOwned_ff && !fifoEmpty && (inLength_ff < LEN_W'(DATA_BYTES)) && state_ff != ST_INIT
                   && !initRise;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxOwned_ff   <= 1'b0;
      rxNotify_ff  <= 1'b0;
      rxAckSeen_ff <= 1'b0;
      inLength_ff  <= '0;
    end else if (initRise || state_ff == ST_INIT) begin
      rxOwned_ff   <= 1'b0;
      inLength_ff  <= '0;
      rxAckSeen_ff <= ctrlWord_ff[CT_RXACK_BIT];
    end else if (rxOwned_ff) begin
      if (rxAckNew) begin
        rxAckSeen_ff <= ctrlWord_ff[CT_RXACK_BIT];
        rxOwned_ff   <= 1'b0;
        inLength_ff  <= '0;
      end
    end else if (fifoPop) begin
      inLength_ff <= inLength_ff + 1'b1;
    end else if (inLength_ff != '0) begin
      rxNotify_ff <= !rxNotify_ff;
      rxOwned_ff  <= 1'b1;
    end else begin
      rxAckSeen_ff <= ctrlWord_ff[CT_RXACK_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (fifoPop) begin
      rxBytes_ff[inLength_ff[5:0]] <= fifo_ff[fifoRd_ff];
    end
  end

  ////////////////////////////////////////////////////////////
  // interrupt status, mask and output
  assign sentEvt = state_ff == ST_WAIT && !phyBusy;
  assign rxEvt   = !rxOwned_ff && !fifoPop && inLength_ff != '0 && state_ff != ST_INIT && !initRise;
  assign initEvt = state_ff == ST_INIT && initCnt_ff == '0 && !phyBusy && !initDone_ff && !initRise;
  assign fullEvt = phyValid && fifoFull;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqStat_ff <= '0;
      irqMask_ff <= MASK_RESET;
      irq        <= 1'b0;
    end else begin
      irqStat_ff <= (statRd ? '0 : irqStat_ff) | {fullEvt, initEvt, rxEvt, sentEvt}; // set wins
      if (regWr && hit(regAddr, OFF_IRQ_MASK)) begin
        irqMask_ff <= regWdata[IRQ_W-1:0];
      end
      irq <= |(irqStat_ff & irqMask_ff);
    end
  end

  ////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= '0;
    end else if (regRd) begin
      if (hit(regAddr, OFF_CTRL)) begin
        regRdata <= ctrlWord_ff;
      end else if (hit(regAddr, OFF_STAT)) begin
        regRdata <= statWord;
      end else if (hit(regAddr, OFF_IRQ_STAT)) begin
        regRdata <= {12'h000, irqStat_ff};
      end else if (hit(regAddr, OFF_IRQ_MASK)) begin
        regRdata <= {12'h000, irqMask_ff};
      end else if (inArr(regAddr, OFF_TX_BASE)) begin
        regRdata <= {8'h00, txBytes_ff[6'(regAddr - OFF_TX_BASE)]};
      end else if (inArr(regAddr, OFF_RX_BASE)) begin
        regRdata <= {8'h00, rxBytes_ff[6'(regAddr - OFF_RX_BASE)]};
      end else begin
        regRdata <= 16'h0000; // unmapped
      end
    end else begin
      regRdata <= 16'h0000;
    end
  end
endmodule // sph_serial_port

// ===== verif/sph_port_checker.sv
// concurrent checks on the serial process-image port
`timescale 1ns/1ps
module sph_port_checker
  import sph_pkg::*;
(
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [15:0]       regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [15:0]       regRdata,
  input wire logic              irq,
  input wire logic              serialTx,
  input wire logic              serialRx
);
  logic [15:0] ctrl_ff;
  logic [3:0]  mask_ff;
  logic [7:0]  initAge_ff;
  logic [7:0]  clrAge_ff;
  logic        sent_ff;
  logic        rxSeen_ff;
  logic        wrCtrl;
  logic        rdStat;
  assign wrCtrl = regWr && regAddr == OFF_CTRL;
  assign rdStat = regRd && regAddr == OFF_STAT;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // shadow of software writes and ages since init edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff    <= CTRL_RESET;
      mask_ff    <= MASK_RESET;
      initAge_ff <= 8'hff;
      clrAge_ff  <= 8'hff;
      sent_ff    <= 1'b0;
      rxSeen_ff  <= 1'b0;
    end else begin
      if (wrCtrl) ctrl_ff <= regWdata;
      if (regWr && regAddr == OFF_IRQ_MASK) mask_ff <= regWdata[3:0];
      if (wrCtrl && regWdata[CT_INIT_BIT] && !ctrl_ff[CT_INIT_BIT]) initAge_ff <= 8'h00;
      else if (initAge_ff != 8'hff) initAge_ff <= initAge_ff + 8'h01;
      if (wrCtrl && !regWdata[CT_INIT_BIT] && ctrl_ff[CT_INIT_BIT]) clrAge_ff <= 8'h00;
      else if (clrAge_ff != 8'hff) clrAge_ff <= clrAge_ff + 8'h01;
      if (wrCtrl && regWdata[CT_SEND_BIT] != ctrl_ff[CT_SEND_BIT]) sent_ff <= 1'b1;
      if (!serialRx) rxSeen_ff <= 1'b1;
    end
  end
  ////////////////////////////////////////
  ctrl_readback_a: assert property (wrCtrl ##1 !regWr ##1 (regRd && regAddr == OFF_CTRL)
    |=> (regRdata & 16'hff07) == ($past(regWdata, 3) & 16'hff07)) else $error("ctrl word readback wrong");
  stat_reserved_a: assert property (rdStat |=> regRdata[7:4] == 4'h0)
    else $error("status reserved bits set");
  idle_rdata_a: assert property (!regRd |=> regRdata == 16'h0000)
    else $error("read data outside read cycle");
  init_wait_a: assert property (rdStat && ctrl_ff[CT_INIT_BIT] && initAge_ff < 8'd10
    |=> !regRdata[SR_IDONE_BIT]) else $error("init done too early");
  init_clear_a: assert property (rdStat && !ctrl_ff[CT_INIT_BIT] && clrAge_ff > 8'd3
    |=> !regRdata[SR_IDONE_BIT]) else $error("init done not cleared");
  irq_mask_a: assert property (irq |-> (mask_ff | $past(mask_ff)) != 4'h0)
    else $error("interrupt with all sources masked");
  tx_start_a: assert property ($fell(serialTx) |=> !serialTx [*8])
    else $error("start bit too short");
  tx_cause_a: assert property ($fell(serialTx) |-> sent_ff)
    else $error("line activity without send toggle");
  rx_empty_a: assert property (rdStat && !rxSeen_ff
    |=> regRdata[15:8] == 8'h00 && !regRdata[SR_RXN_BIT]) else $error("receive count without traffic");
endmodule // sph_port_checker

// ===== verif/sph_line_peer.sv
// far-side serial line model, 8N1 lsb first, idle high
`timescale 1ns/1ps
module sph_line_peer
  import sph_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       serialTx,
  output logic            serialRx,
  output logic            gotByte,
  output logic [7:0]      gotData
);
  logic [7:0] sh;
  initial begin
    serialRx = 1'b1;
    gotByte  = 1'b0;
    gotData  = 8'h00;
  end
  // send one frame, line back to idle after stop bit
  task automatic send_byte(input logic [7:0] b);
    serialRx <= 1'b0;
    repeat (BIT_CYCLES) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      serialRx <= b[i];
      repeat (BIT_CYCLES) @(posedge clk);
    end
    serialRx <= 1'b1;
    repeat (BIT_CYCLES) @(posedge clk);
  endtask
  // sample mid-bit; a low stop bit drops the frame
  always begin
    @(negedge serialTx);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      sh[i] = serialTx;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    gotData <= sh;
    gotByte <= serialTx;
    @(posedge clk);
    gotByte <= 1'b0;
  end
endmodule // sph_line_peer

// ===== verif/tb.sv
// self-checking bench for the serial process-image port
`timescale 1ns/1ps
module tb
  import sph_pkg::*;
;
  logic              clk;
  logic              nrst;
  logic [ADDR_W-1:0] regAddr;
  logic [15:0]       regWdata;
  logic              regWr;
  logic              regRd;
  logic [15:0]       regRdata;
  logic              irq;
  logic              serialTx;
  logic              serialRx;
  logic              gotByte;
  logic [7:0]        gotData;
  logic              rdPend;
  logic [31:0]       seed;
  logic [31:0]       e;
  logic [7:0]        txb [2];
  logic [7:0]        rxb [2];
  logic [31:0]       expQ [$];
  logic [7:0]        expTx [$];
  int                fail_count;
  int                samples_checked;
  sph_serial_port i_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .irq(irq), .serialTx(serialTx), .serialRx(serialRx));
  sph_line_peer i_peer (.clk(clk), .serialTx(serialTx), .serialRx(serialRx), .gotByte(gotByte),
    .gotData(gotData));
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chkReg(input string what, input logic [15:0] x, input logic [15:0] g, input logic [15:0] m);
    samples_checked++;
    if ((g & m) !== (x & m)) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, x & m, g & m);
    end
  endtask
  task automatic chkByte(input logic [7:0] x, input logic [7:0] g);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] serialByte expected %h seen %h", x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x, input logic [15:0] m);
    expQ.push_back({m, x});
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // take the oldest note whenever read data or a line byte appears
  always @(posedge clk) begin
    rdPend <= regRd;
    if (rdPend && expQ.size() > 0) begin
      e = expQ.pop_front();
      chkReg("regRdata", e[15:0], regRdata, e[31:16]);
    end
    if (gotByte) begin
      if (expTx.size() > 0) chkByte(expTx.pop_front(), gotData);
      else chkByte(~gotData, gotData);
    end
  end
  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    nrst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWdata = 16'h0000;
    rdPend = 1'b0;
    seed = 32'h86fd;
    fail_count = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(OFF_CTRL, CTRL_RESET, 16'hffff);
    rd(OFF_STAT, 16'h0000, 16'hffff);
    rd(OFF_IRQ_MASK, {12'h000, MASK_RESET}, 16'hffff);
    wr(OFF_STAT, 16'hffff);
    wr(8'h10, 16'hffff);
    rd(OFF_STAT, 16'h0000, 16'hffff);
    rd(8'h10, 16'h0000, 16'hffff);
    wr(OFF_IRQ_MASK, 16'h0007);
    rd(OFF_IRQ_MASK, 16'h0007, 16'hffff);
    // initialization handshake and its interrupt
    wr(OFF_CTRL, 16'h0004);
    rd(OFF_STAT, 16'h0000, 16'h0004);
    repeat (INIT_CYCLES + 20) @(posedge clk);
    rd(OFF_STAT, 16'h0004, 16'hffff);
    chkReg("irq", 16'h0001, {15'h0000, irq}, 16'h0001);
    rd(OFF_IRQ_STAT, 16'h0004, 16'hffff);
    repeat (2) @(posedge clk);
    chkReg("irq", 16'h0000, {15'h0000, irq}, 16'h0001);
    wr(OFF_CTRL, 16'h0000);
    repeat (5) @(posedge clk);
    rd(OFF_STAT, 16'h0000, 16'hffff);
    // two bytes out while two bytes come in
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      txb[i] = seed[7:0];
      seed = lfsr(seed);
      rxb[i] = seed[7:0];
      expTx.push_back(txb[i]);
      wr(OFF_TX_BASE + 8'(i), {8'h00, txb[i]});
    end
    rd(OFF_TX_BASE, {8'h00, txb[0]}, 16'h00ff);
    fork
      begin
        i_peer.send_byte(rxb[0]);
        i_peer.send_byte(rxb[1]);
      end
    join_none
    wr(OFF_CTRL, 16'h0201);
    rd(OFF_CTRL, 16'h0201, 16'hff07);
    for (int n = 0; n < 40000 && expTx.size() > 0; n++) @(posedge clk);
    repeat (2000) @(posedge clk);
    chkReg("irq", 16'h0001, {15'h0000, irq}, 16'h0001);
    rd(OFF_STAT, 16'h0103, 16'hffff);
    rd(OFF_RX_BASE, {8'h00, rxb[0]}, 16'hffff);
    rd(OFF_IRQ_STAT, 16'h0003, 16'hffff);
    wr(OFF_CTRL, 16'h0203);
    repeat (20) @(posedge clk);
    rd(OFF_STAT, 16'h0101, 16'hffff);
    rd(OFF_RX_BASE, {8'h00, rxb[1]}, 16'hffff);
    // reinitialization empties the receive side
    wr(OFF_CTRL, 16'h0207);
    repeat (INIT_CYCLES + 20) @(posedge clk);
    rd(OFF_STAT, 16'h0004, 16'hff0c);
    wr(OFF_CTRL, 16'h0203);
    repeat (5) @(posedge clk);
    rd(OFF_STAT, 16'h0000, 16'h0004);
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule // tb
bind sph_serial_port sph_port_checker i_chk (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq), .serialTx(serialTx), .serialRx(serialRx));
